// [hw/cbcfg_pkg.sv]
// Constants and helpers for the bridge configuration header slice.
// Assumes one clock domain and dword-wide configuration accesses.
package cbcfg_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_FUNC = 2;
    localparam int NUM_EVT = 6;

    // ------------------------------------------------------------
    // Byte offsets in configuration space
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_LAYOUT = 8'h0e;
    localparam logic [7:0] OFF_SELF_TEST = 8'h0f;
    localparam logic [7:0] OFF_WIN_BASE = 8'h10;
    localparam logic [7:0] OFF_CAP_PTR = 8'h14;
    localparam logic [7:0] OFF_DS_STATUS = 8'h16;
    localparam logic [7:0] OFF_HDR_LAST = 8'h7f;
    localparam logic [7:0] OFF_PM_CAP0 = 8'ha0;
    localparam logic [7:0] OFF_PM_CAP1 = 8'ha4;

    // ------------------------------------------------------------
    // Fixed and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LAYOUT_VAL = 8'h82;
    localparam logic [7:0] SELF_TEST_VAL = 8'h00;
    localparam logic [7:0] CAP_PTR_VAL = 8'ha0;
    localparam logic [19:0] WIN_BASE_RST = 20'h00000;
    localparam logic [15:0] STATUS_RST = 16'h0200;
    localparam logic [15:0] STATUS_W1C_MASK = 16'hf900;
    localparam logic [1:0] SELECT_TIMING_VAL = 2'h1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WIN_BASE_LSB = 12;
    localparam int WIN_LEGACY_BIT = 11;
    localparam int ST_PARITY = 15;
    localparam int ST_SERR = 14;
    localparam int ST_MABORT = 13;
    localparam int ST_TA_RCV = 12;
    localparam int ST_TA_SIG = 11;
    localparam int ST_SEL_LSB = 9;
    localparam int ST_DPAR = 8;

    // Event vector order toward a function slice
    localparam int EV_PARITY = 0;
    localparam int EV_SERR = 1;
    localparam int EV_MABORT = 2;
    localparam int EV_TA_RCV = 3;
    localparam int EV_TA_SIG = 4;
    localparam int EV_DPAR = 5;

    // Byte-enable merge of a write into a stored dword
    function automatic logic [31:0] cbcfg_merge(
        input logic [31:0] cur,
        input logic [31:0] wdat,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = cur;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// [hw/cbcfg_fn_if.sv]
// Carrier between the header decoder and one per-function slice.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface cbcfg_fn_if;
    logic wr_base;
    logic wr_stat;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [5:0] ev;
    logic [19:0] base;
    logic [15:0] status;

    modport main (
        output wr_base,
        output wr_stat,
        output be,
        output wdata,
        output ev,
        input base,
        input status
    );

    modport fn (
        input wr_base,
        input wr_stat,
        input be,
        input wdata,
        input ev,
        output base,
        output status
    );
endinterface

// [hw/cbcfg_func_regs.sv]
// Per-function window base and downstream status registers.
// Assumes strobes are one-cycle pulses already decoded by the top.
`timescale 1ns/1ps
module cbcfg_func_regs
    import cbcfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    cbcfg_fn_if.fn bus
);

    logic [19:0] base_ff;
    logic [15:0] status_ff;
    logic [31:0] base_word;
    logic [31:0] nxt_base_word;
    logic [15:0] clr_mask;
    logic [15:0] set_mask;
    logic [15:0] nxt_status;

    // ------------------------------------------------------------
    // Window base
    // ------------------------------------------------------------
    // Low twelve bits never stored, so all-ones reads FFFFF000
    assign base_word = {base_ff, 12'h000}; // [R5]
    assign nxt_base_word = cbcfg_merge(base_word, bus.wdata, bus.be);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            base_ff <= WIN_BASE_RST;
        else if (bus.wr_base)
            base_ff <= nxt_base_word[31:WIN_BASE_LSB]; // [R4] [R6]
    end

    // ------------------------------------------------------------
    // Downstream status
    // ------------------------------------------------------------
    always_comb
    begin
        clr_mask = 16'h0000;
        if (bus.wr_stat)
        begin
            clr_mask[15:8] = bus.be[3] ? bus.wdata[31:24] : 8'h00;
            clr_mask[7:0] = bus.be[2] ? bus.wdata[23:16] : 8'h00;
        end
        clr_mask = clr_mask & STATUS_W1C_MASK; // [R11]
        set_mask = 16'h0000;
        set_mask[ST_PARITY] = bus.ev[EV_PARITY]; // [R12]
        set_mask[ST_SERR] = bus.ev[EV_SERR]; // [R13]
        set_mask[ST_MABORT] = bus.ev[EV_MABORT]; // [R14]
        set_mask[ST_TA_RCV] = bus.ev[EV_TA_RCV]; // [R15]
        set_mask[ST_TA_SIG] = bus.ev[EV_TA_SIG]; // [R16]
        set_mask[ST_DPAR] = bus.ev[EV_DPAR]; // [R18]
        // Set beats clear so a same-cycle event is kept
        nxt_status = (status_ff & ~clr_mask) | set_mask; // [R11]
        nxt_status = nxt_status & STATUS_W1C_MASK;
        nxt_status[ST_SEL_LSB +: 2] = SELECT_TIMING_VAL; // [R17]
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status_ff <= STATUS_RST; // [R11]
        else
            status_ff <= nxt_status;
    end

    assign bus.base = base_ff; // [R8]
    assign bus.status = status_ff; // [R8]

endmodule

// [hw/cbcfg_bridge_hdr.sv]
// Bridge configuration header slice, offsets 0Eh to 17h, two functions.
// Assumes a one-dword configuration port on the bridge clock and
// card-side error detectors that pulse on the same clock.
`timescale 1ns/1ps

// Operation
// [R1] Layout code byte always reads 82h in both functions.
// [R2] Offsets 0-7Fh are standard header; 80h-FFh are extension space.
// [R3] Self-test byte reads 00h; writes do nothing.
// [R4] Window base bits 31-12 are writable, 4-Kbyte aligned base.
// [R5] Window base bits 11-0 always read zero.
// [R6] Writing all ones to window base reads back FFFFF000h.
// [R7] Window hits reach socket regs at 000h, legacy set at 800h.
// [R8] Each function keeps its own window base register.
// [R9] Capability pointer is read-only, per function, reads A0h.
// [R10] Power capability dwords sit at A0h and A4h per function.
// [R11] Status resets to 0200h; flags clear only by writing one.
// [R12] Bit 15 sets on card-side address or data parity error.
// [R13] Bit 14 sets on card system error; bridge never drives it.
// [R14] Bit 13 sets on master abort of a bridge-initiated cycle.
// [R15] Bit 12 sets on target abort received by bridge as master.
// [R16] Bit 11 sets when bridge as target signals target abort.
// [R17] Bits 10-9 are fixed 01b, medium select timing.
// [R18] Bit 8 sets on parity error while master with response enabled.
// [R19] Writes to read-only positions complete and change nothing.
module cbcfg_bridge_hdr
    import cbcfg_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    // Configuration access port
    input wire logic CFG_REQ_I,
    input wire logic CFG_WR_I,
    input wire logic CFG_FUNC_I,
    input wire logic [7:2] CFG_ADDR_I,
    input wire logic [3:0] CFG_BE_I,
    input wire logic [31:0] CFG_WDATA_I,
    output logic CFG_ACK_O,
    output logic [31:0] CFG_RDATA_O,
    // Power capability block outside this slice
    input wire logic [31:0] PM_RDATA_I,
    output logic PM_HIT_O,
    // Card-side event detectors, one bit per function
    input wire logic [1:0] CARD_PARITY_ERR_I,
    input wire logic [1:0] CARD_SERR_I,
    input wire logic [1:0] CARD_MABORT_I,
    input wire logic [1:0] CARD_TABORT_RCV_I,
    input wire logic [1:0] CARD_TABORT_SIG_I,
    input wire logic [1:0] CARD_PERR_I,
    input wire logic [1:0] CARD_MASTER_I,
    input wire logic [1:0] PARITY_RESP_EN_I,
    output logic CARD_SERR_OE_O,
    // Memory window decode
    input wire logic MEM_REQ_I,
    input wire logic [31:0] MEM_ADDR_I,
    output logic [1:0] MEM_HIT_O,
    output logic MEM_LEGACY_O,
    output logic [10:0] MEM_OFFSET_O
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // True when the dword address covers the given byte offset
    function automatic logic dw_hit(
        input logic [7:2] dw,
        input logic [7:0] off
    );
        return dw == off[7:2];
    endfunction

    // True when the address falls inside a programmed window
    function automatic logic win_hit(
        input logic [31:0] addr,
        input logic [19:0] base
    );
        return (base != 20'h00000) && (addr[31:WIN_BASE_LSB] == base);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic cfg_ack_ff;
    logic [31:0] cfg_rdata_ff;
    logic [31:0] nxt_rdata;
    logic pm_hit_ff;
    logic serr_oe_ff;
    logic [1:0] mem_hit_ff;
    logic [1:0] nxt_mem_hit;
    logic mem_legacy_ff;
    logic [10:0] mem_offset_ff;
    logic in_std_hdr;
    logic is_pm_dword;
    logic is_id_dword;
    logic is_base_dword;
    logic is_cap_dword;
    logic wr_take;
    logic [19:0] base_of [NUM_FUNC];
    logic [15:0] status_of [NUM_FUNC];
    logic [5:0] ev_of [NUM_FUNC];

    cbcfg_fn_if fn_bus [NUM_FUNC] ();

    // ------------------------------------------------------------
    // Address classes
    // ------------------------------------------------------------
    // Upper half is extension space; only the power dwords live here
    assign in_std_hdr = ({CFG_ADDR_I, 2'b00} <= OFF_HDR_LAST); // [R2]
    assign is_id_dword = dw_hit(CFG_ADDR_I, OFF_LAYOUT);
    assign is_base_dword = dw_hit(CFG_ADDR_I, OFF_WIN_BASE);
    assign is_cap_dword = dw_hit(CFG_ADDR_I, OFF_CAP_PTR);
    assign is_pm_dword = dw_hit(CFG_ADDR_I, OFF_PM_CAP0)
        || dw_hit(CFG_ADDR_I, OFF_PM_CAP1); // [R10]
    assign wr_take = CFG_REQ_I && CFG_WR_I;

    // ------------------------------------------------------------
    // Event collection per function
    // ------------------------------------------------------------
    genvar gf;
    generate
        for (gf = 0; gf < NUM_FUNC; gf++)
        begin : g_func
            always_comb
            begin
                ev_of[gf] = 6'h00;
                ev_of[gf][EV_PARITY] = CARD_PARITY_ERR_I[gf]; // [R12]
                ev_of[gf][EV_SERR] = CARD_SERR_I[gf]; // [R13]
                ev_of[gf][EV_MABORT] = CARD_MABORT_I[gf]; // [R14]
                ev_of[gf][EV_TA_RCV] = CARD_TABORT_RCV_I[gf]; // [R15]
                ev_of[gf][EV_TA_SIG] = CARD_TABORT_SIG_I[gf]; // [R16]
                // All three conditions must meet in the same cycle
                ev_of[gf][EV_DPAR] = CARD_PERR_I[gf]
                    && CARD_MASTER_I[gf]
                    && PARITY_RESP_EN_I[gf]; // [R18]
            end

            // Only the dwords holding writable bits raise a strobe
            assign fn_bus[gf].wr_base = wr_take
                && (CFG_FUNC_I == gf[0])
                && is_base_dword; // [R8] [R19]
            assign fn_bus[gf].wr_stat = wr_take
                && (CFG_FUNC_I == gf[0])
                && is_cap_dword; // [R11] [R19]
            assign fn_bus[gf].be = CFG_BE_I;
            assign fn_bus[gf].wdata = CFG_WDATA_I;
            assign fn_bus[gf].ev = ev_of[gf];
            assign base_of[gf] = fn_bus[gf].base;
            assign status_of[gf] = fn_bus[gf].status;

            cbcfg_func_regs u_regs (
                .clk_i(CLK_I),
                .rst_i(RST_I),
                .bus(fn_bus[gf])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Cache line and latency bytes of the id dword belong elsewhere
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        if (is_id_dword)
        begin
            nxt_rdata[31:24] = SELF_TEST_VAL; // [R3]
            nxt_rdata[23:16] = LAYOUT_VAL; // [R1]
        end
        else if (is_base_dword)
        begin
            nxt_rdata = {base_of[CFG_FUNC_I], 12'h000}; // [R5] [R6]
        end
        else if (is_cap_dword)
        begin
            nxt_rdata[31:16] = status_of[CFG_FUNC_I];
            nxt_rdata[7:0] = CAP_PTR_VAL; // [R9]
        end
        else if (is_pm_dword)
        begin
            nxt_rdata = PM_RDATA_I; // [R10]
        end
        else if (!in_std_hdr)
        begin
            // Unclaimed extension dwords read zero
            nxt_rdata = 32'h00000000; // [R2]
        end
    end

    // ------------------------------------------------------------
    // Configuration answer
    // ------------------------------------------------------------
    // Every request answers next cycle, reads and writes alike
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            cfg_ack_ff <= 1'b0;
        else
            cfg_ack_ff <= CFG_REQ_I; // [R19]
    end

    // Writes return zero data; nothing on the bus reads it
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            cfg_rdata_ff <= 32'h00000000;
        else if (CFG_REQ_I && !CFG_WR_I)
            cfg_rdata_ff <= nxt_rdata;
        else if (CFG_REQ_I)
            cfg_rdata_ff <= 32'h00000000;
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            pm_hit_ff <= 1'b0;
        else
            pm_hit_ff <= CFG_REQ_I && is_pm_dword; // [R10]
    end

    // ------------------------------------------------------------
    // Card system error pin
    // ------------------------------------------------------------
    // Kept as a flop so the pin enable is defined from reset on
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            serr_oe_ff <= 1'b0;
        else
            serr_oe_ff <= 1'b0; // [R13]
    end

    // ------------------------------------------------------------
    // Memory window decode
    // ------------------------------------------------------------
    // A zero base counts as unassigned, so reset leaves no window
    generate
        for (gf = 0; gf < NUM_FUNC; gf++)
        begin : g_win
            assign nxt_mem_hit[gf] = MEM_REQ_I
                && win_hit(MEM_ADDR_I, base_of[gf]); // [R7] [R8]
        end
    endgenerate

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            mem_hit_ff <= 2'h0;
        else
            mem_hit_ff <= nxt_mem_hit; // [R7]
    end

    // Offset bit 11 splits socket set from legacy set
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            mem_legacy_ff <= 1'b0;
        else if (nxt_mem_hit != 2'h0)
            mem_legacy_ff <= MEM_ADDR_I[WIN_LEGACY_BIT]; // [R7]
        else
            mem_legacy_ff <= 1'b0;
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            mem_offset_ff <= 11'h000;
        else if (nxt_mem_hit != 2'h0)
            mem_offset_ff <= MEM_ADDR_I[10:0]; // [R7]
        else
            mem_offset_ff <= 11'h000;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign CFG_ACK_O = cfg_ack_ff;
    assign CFG_RDATA_O = cfg_rdata_ff;
    assign PM_HIT_O = pm_hit_ff;
    assign CARD_SERR_OE_O = serr_oe_ff;
    assign MEM_HIT_O = mem_hit_ff;
    assign MEM_LEGACY_O = mem_legacy_ff;
    assign MEM_OFFSET_O = mem_offset_ff;

endmodule

// [dv/cbcfg_bridge_hdr_assertions.sv]
// Port-level checks for the bridge configuration header slice.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cbcfg_bridge_hdr_assertions
    import cbcfg_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CFG_REQ_I,
    input wire logic CFG_WR_I,
    input wire logic CFG_FUNC_I,
    input wire logic [7:2] CFG_ADDR_I,
    input wire logic CFG_ACK_O,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic [31:0] PM_RDATA_I,
    input wire logic PM_HIT_O,
    input wire logic [1:0] CARD_MABORT_I,
    input wire logic CARD_SERR_OE_O,
    input wire logic MEM_REQ_I,
    input wire logic [31:0] MEM_ADDR_I,
    input wire logic [1:0] MEM_HIT_O,
    input wire logic MEM_LEGACY_O,
    input wire logic [10:0] MEM_OFFSET_O
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic rd;
    logic pm;
    assign rd = CFG_REQ_I && !CFG_WR_I;
    assign pm = CFG_ADDR_I == 6'h28 || CFG_ADDR_I == 6'h29;
    // Abort pulse, an idle cycle, then a status read of that function
    sequence s_abort_f1;
        CARD_MABORT_I[1] ##1 !CFG_REQ_I
            ##1 (rd && CFG_FUNC_I && CFG_ADDR_I == 6'h05);
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_ACK: assert property (CFG_REQ_I |=> CFG_ACK_O)
        else $error("config ack missing");
    AST_IDLE: assert property (!CFG_REQ_I |=> !CFG_ACK_O && !PM_HIT_O)
        else $error("ack without request");
    AST_WR_ZERO: assert property (CFG_REQ_I && CFG_WR_I |=>
        CFG_RDATA_O == 32'h0)
        else $error("write returned data");
    AST_LAYOUT: assert property (rd && CFG_ADDR_I == 6'h03 |=>
        CFG_RDATA_O == 32'h00820000)
        else $error("layout or self test byte wrong");
    // Bit 24 carries the data parity flag, so only 26:25 are fixed
    AST_CAP: assert property (rd && CFG_ADDR_I == 6'h05 |=>
        CFG_RDATA_O[26:25] == 2'h1 && CFG_RDATA_O[23:0] == 24'h0000a0)
        else $error("pointer or fixed status bits wrong");
    AST_BASE_LO: assert property (rd && CFG_ADDR_I == 6'h04 |=>
        CFG_RDATA_O[11:0] == 12'h000)
        else $error("window base low bits set");
    AST_PM: assert property (rd && pm |=> PM_HIT_O
        && CFG_RDATA_O == $past(PM_RDATA_I))
        else $error("power capability dword not served");
    AST_EXT: assert property (rd && CFG_ADDR_I >= 6'h20 && !pm |=>
        CFG_RDATA_O == 32'h0 && !PM_HIT_O)
        else $error("extension space not zero");
    AST_ABORT: assert property (s_abort_f1 |=> CFG_RDATA_O[29])
        else $error("master abort flag not seen");
    AST_SERR_OE: assert property (!CARD_SERR_OE_O)
        else $error("bridge drives card system error");
    AST_NOMEM: assert property (!MEM_REQ_I |=>
        MEM_HIT_O == 2'h0 && !MEM_LEGACY_O)
        else $error("window hit without request");
    AST_MEMOFF: assert property (MEM_REQ_I ##1 MEM_HIT_O != 2'h0 |->
        MEM_OFFSET_O == 11'($past(MEM_ADDR_I))
        && MEM_LEGACY_O == 1'($past(MEM_ADDR_I) >> 11))
        else $error("window offset wrong");
endmodule

bind cbcfg_bridge_hdr cbcfg_bridge_hdr_assertions i_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .CFG_REQ_I(CFG_REQ_I),
    .CFG_WR_I(CFG_WR_I), .CFG_FUNC_I(CFG_FUNC_I), .CFG_ADDR_I(CFG_ADDR_I),
    .CFG_ACK_O(CFG_ACK_O), .CFG_RDATA_O(CFG_RDATA_O),
    .PM_RDATA_I(PM_RDATA_I), .PM_HIT_O(PM_HIT_O),
    .CARD_MABORT_I(CARD_MABORT_I), .CARD_SERR_OE_O(CARD_SERR_OE_O),
    .MEM_REQ_I(MEM_REQ_I), .MEM_ADDR_I(MEM_ADDR_I), .MEM_HIT_O(MEM_HIT_O),
    .MEM_LEGACY_O(MEM_LEGACY_O), .MEM_OFFSET_O(MEM_OFFSET_O)
);

// [dv/cbcfg_card_model.sv]
// Card-side error detector stand-in for the header slice.
// Assumes the bench holds go_i for one clock per event.
`timescale 1ns/1ps
module cbcfg_card_model
(
    input wire logic go_i,
    input wire logic fn_i,
    input wire logic [2:0] kind_i,
    output logic [1:0] parity_o,
    output logic [1:0] serr_o,
    output logic [1:0] mabort_o,
    output logic [1:0] ta_rcv_o,
    output logic [1:0] ta_sig_o,
    output logic [1:0] perr_o,
    output logic [1:0] master_o,
    output logic [1:0] resp_o
);
    // ------------------------------------------------------------
    // Event pulses
    // ------------------------------------------------------------
    // Combinational so every line is defined from time zero
    logic [1:0] sel;
    assign sel = go_i ? (2'h1 << fn_i) : 2'h0;
    assign parity_o = kind_i == 3'h0 ? sel : 2'h0;
    assign serr_o = kind_i == 3'h1 ? sel : 2'h0;
    assign mabort_o = kind_i == 3'h2 ? sel : 2'h0;
    assign ta_rcv_o = kind_i == 3'h3 ? sel : 2'h0;
    assign ta_sig_o = kind_i == 3'h4 ? sel : 2'h0;
    // Kinds 6 and 7 each drop one qualifier of the data parity flag
    assign perr_o = kind_i >= 3'h5 ? sel : 2'h0;
    assign master_o = kind_i != 3'h7 ? sel : 2'h0;
    assign resp_o = kind_i != 3'h6 ? sel : 2'h0;
endmodule

// [dv/testbench.sv]
// Self-checking bench for the header slice and card-side stand-in.
// Assumes the design package, carrier and modules compile first.
`timescale 1ns/1ps
module testbench
    import cbcfg_pkg::*;
();
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0, wr = 1'b0, fn = 1'b0, mreq = 1'b0;
    logic go = 1'b0, efn = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [7:2] addr = 6'h00;
    logic [3:0] be = 4'h0;
    logic [31:0] wdat = 32'h0, pm = 32'h0, maddr = 32'h0;
    logic ack, pmhit, oe, leg;
    logic [31:0] rdat, got;
    logic [1:0] hit, par, serr, mab, tar, tas, perr, mst, resp;
    logic [10:0] moff;
    logic [19:0] base_exp [2];
    logic [15:0] st_exp [2];
    logic [7:0] offs [7] = '{8'h0c, 8'h10, 8'h14, 8'ha0, 8'ha4,
        8'h80, 8'h7c};
    int failures = 0, total_checks = 0;

    always #20 clk = ~clk;

    cbcfg_bridge_hdr i_cbcfg_bridge_hdr (
        .CLK_I(clk), .RST_I(rst), .CFG_REQ_I(req), .CFG_WR_I(wr),
        .CFG_FUNC_I(fn), .CFG_ADDR_I(addr), .CFG_BE_I(be),
        .CFG_WDATA_I(wdat), .CFG_ACK_O(ack), .CFG_RDATA_O(rdat),
        .PM_RDATA_I(pm), .PM_HIT_O(pmhit), .CARD_PARITY_ERR_I(par),
        .CARD_SERR_I(serr), .CARD_MABORT_I(mab), .CARD_TABORT_RCV_I(tar),
        .CARD_TABORT_SIG_I(tas), .CARD_PERR_I(perr), .CARD_MASTER_I(mst),
        .PARITY_RESP_EN_I(resp), .CARD_SERR_OE_O(oe), .MEM_REQ_I(mreq),
        .MEM_ADDR_I(maddr), .MEM_HIT_O(hit), .MEM_LEGACY_O(leg),
        .MEM_OFFSET_O(moff)
    );

    cbcfg_card_model i_cbcfg_card_model (
        .go_i(go), .fn_i(efn), .kind_i(kind), .parity_o(par),
        .serr_o(serr), .mabort_o(mab), .ta_rcv_o(tar), .ta_sig_o(tas),
        .perr_o(perr), .master_o(mst), .resp_o(resp)
    );

    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] exp_rd(input logic f,
        input logic [7:0] o);
        case (o)
            8'h0c: return 32'h00820000;
            8'h10: return {base_exp[f], 12'h000};
            8'h14: return {st_exp[f], 16'h00a0};
            8'ha0, 8'ha4: return pm;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [1:0] exp_hit(input logic [31:0] a);
        for (int f = 0; f < 2; f++)
        begin
            exp_hit[f] = base_exp[f] != 20'h0 && a[31:12] == base_exp[f];
        end
    endfunction

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cfg(input logic w, input logic f, input logic [7:0] o,
        input logic [3:0] b, input logic [31:0] d);
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        fn <= f;
        addr <= o[7:2];
        be <= b;
        wdat <= d;
        pm <= $urandom;
        @(posedge clk);
        req <= 1'b0;
        #1;
        got = rdat;
        check("ack", {31'h0, ack}, 32'h1);
        check("pm_hit", {31'h0, pmhit},
            {31'h0, o == 8'ha0 || o == 8'ha4});
    endtask

    task automatic rdchk(input logic f, input logic [7:0] o);
        cfg(1'b0, f, o, 4'h0, 32'h0);
        check("read", got, exp_rd(f, o));
    endtask

    // Reserved and fixed bits never change, whatever is written
    task automatic wrt(input logic f, input logic [7:0] o,
        input logic [3:0] b, input logic [31:0] d);
        cfg(1'b1, f, o, b, d);
        if (o == 8'h10 && b[1])
            base_exp[f][3:0] = d[15:12];
        if (o == 8'h10 && b[2])
            base_exp[f][11:4] = d[23:16];
        if (o == 8'h10 && b[3])
            base_exp[f][19:12] = d[31:24];
        if (o == 8'h14)
            st_exp[f] &= ~(d[31:16] & 16'hf900 & {{8{b[3]}}, {8{b[2]}}});
    endtask

    task automatic mem(input logic [31:0] a);
        logic [1:0] h;
        h = exp_hit(a);
        @(posedge clk);
        mreq <= 1'b1;
        maddr <= a;
        @(posedge clk);
        mreq <= 1'b0;
        #1;
        check("mem", {hit, leg, moff},
            {h, h != 2'h0 ? a[11:0] : 12'h0});
    endtask

    task automatic ev(input logic f, input logic [2:0] k);
        @(posedge clk);
        go <= 1'b1;
        efn <= f;
        kind <= k;
        @(posedge clk);
        go <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(78755));
        base_exp = '{20'h0, 20'h0};
        st_exp = '{16'h0200, 16'h0200};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 14; i++)
            rdchk(i[0], offs[i / 2]);
        wrt(0, 8'h0c, 4'hf, 32'hffffffff);
        wrt(0, 8'h14, 4'h3, 32'hffffffff);
        rdchk(0, 8'h0c);
        rdchk(0, 8'h14);
        wrt(0, 8'h10, 4'hf, 32'hffffffff);
        rdchk(0, 8'h10);
        rdchk(1, 8'h10);
        wrt(1, 8'h10, 4'hf, $urandom | 32'h00001000);
        wrt(1, 8'h10, 4'h3, 32'h00005aff);
        rdchk(1, 8'h10);
        mem(32'hfffff804);
        mem({base_exp[1], 12'h7ff});
        for (int i = 0; i < 12; i++)
            mem(i[0] ? $urandom : {base_exp[i[1]], 12'($urandom)});
        for (int f = 0; f < 2; f++)
            for (int k = 0; k < 8; k++)
            begin
                ev(f, k);
                st_exp[f] = 16'h0200 | (k < 5 ? 16'h8000 >> k : 16'h0);
                st_exp[f] |= k == 5 ? 16'h0100 : 16'h0;
                rdchk(f, 8'h14);
                rdchk(!f, 8'h14);
                wrt(f, 8'h14, 4'hc, 32'h0);
                rdchk(f, 8'h14);
                wrt(f, 8'h14, 4'hc, 32'hffffffff);
                rdchk(f, 8'h14);
            end
        for (int i = 0; i < 40; i++)
        begin
            if (i % 3 == 0)
                wrt(i[1], offs[$urandom % 7], 4'($urandom), $urandom);
            else
                rdchk(i[1], offs[$urandom % 7]);
        end
        wrt(0, 8'h10, 4'hf, 32'h0);
        mem(32'h00000804);
        final_report();
    end

    initial
    begin
        #2000000;
        failures++;
        final_report();
    end
endmodule
